// File: fclr_regs.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// [R1] min duty writes ignored in automatic mode
// [R2] min duty code maps linearly to duty
// [R3] above start temp fan ramps from minimum
// [R4] start temps read-only after lock bit
// [R5] limits, hysteresis, test, offset lock too
// [R6] any channel over limit forces full duty
// [R7] limit code 0x80 disables that failsafe
// [R8] full duty holds until below limit minus hyst
// [R9] quarter degree over limit drives pin low
// [R10] hysteresis kept as 4-bit nibble fields
// [R11] fan stays at minimum down to start minus hyst
// [R12] software keeps hysteresis at four or more
// [R13] tree test bit selects test mode
// [R14] software leaves test reserved bits alone
// [R15] signed half-degree offset added to remote 1
// [R16] thresholds compared in reading code
module fclr_regs
   import fclr_pkg::*;
#(
   parameter int RAMP_SHIFT = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [9:0] remote1_temp,
   input wire logic [9:0] local_temp,
   input wire logic [9:0] remote2_temp,
   input wire logic overtemp_pin_i,
   output logic overtemp_pin_o,
   output logic overtemp_pin_oe,
   output logic [7:0] fan1_duty,
   output logic [7:0] fan2_duty,
   output logic [7:0] fan3_duty,
   output logic [2:0] pwm_out,
   output logic tree_test_mode,
   output logic irq
);

   // ************************************************************
   // helpers
   // ************************************************************
   // register codes become quarter-degree readings (two fraction bits)
   function automatic logic [9:0] to_q(input logic [7:0] code);
      to_q = {code, 2'b00};
   endfunction : to_q

   // threshold minus hysteresis, floored at zero
   function automatic logic [9:0] minus_hyst(input logic [7:0] code, input logic [3:0] hyst);
      logic [10:0] diff;
      diff = {1'b0, to_q(code)} - {5'b00000, hyst, 2'b00};
      minus_hyst = diff[10] ? 10'h000 : diff[9:0];
   endfunction : minus_hyst

   // ************************************************************
   // register storage
   // ************************************************************
   logic [7:0] min_duty [NUM_CH];
   logic [7:0] fan_start_temp [NUM_CH];
   logic [7:0] crit_limit [NUM_CH];
   logic [7:0] remote1_local_hysteresis;
   logic [7:0] remote2_hysteresis;
   logic [7:0] tree_test_enable;
   logic [7:0] remote1_temp_offset;
   logic [2:0] fan_control;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;

   logic [IDX_W-1:0] idx;
   logic addr_ok;
   logic mapped;
   logic wr_en;
   logic locked;
   logic auto_fan_loop;
   logic [DATA_W-1:0] rd_value;

   logic pin_meta;
   logic pin_sync;
   logic [9:0] q_temp [NUM_CH];
   logic [3:0] hyst [NUM_CH];
   logic [NUM_CH-1:0] fan_active;
   logic [NUM_CH-1:0] next_fan_active;
   logic [NUM_CH-1:0] crit_hit;
   logic [NUM_CH-1:0] next_crit_hit;
   logic [NUM_CH-1:0] quarter_over;
   logic [7:0] next_duty [NUM_CH];
   logic [7:0] duty [NUM_CH];
   logic [7:0] pwm_cnt;
   logic [IRQ_W-1:0] irq_event;
   assign idx = paddr[IDX_W+1:2];
   assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:IDX_W+2] == '0);
   assign locked = fan_control[CTRL_LOCK_BIT];
   assign auto_fan_loop = fan_control[CTRL_AUTO_FAN_LOOP_BIT];
   assign wr_en = psel && penable && pready && pwrite && pstrb[0] && mapped;

   // ************************************************************
   // address decode and read mux
   // ************************************************************
   always_comb begin
      mapped = addr_ok;
      rd_value = '0;
      case (addr_ok ? idx : 8'h00)
         IDX_FAN1_MIN_DUTY: rd_value[7:0] = min_duty[0];
         IDX_FAN2_MIN_DUTY: rd_value[7:0] = min_duty[1];
         IDX_FAN3_MIN_DUTY: rd_value[7:0] = min_duty[2];
         IDX_REMOTE1_FAN_START_TEMP: rd_value[7:0] = fan_start_temp[0];
         IDX_LOCAL_FAN_START_TEMP: rd_value[7:0] = fan_start_temp[1];
         IDX_REMOTE2_FAN_START_TEMP: rd_value[7:0] = fan_start_temp[2];
         IDX_REMOTE1_CRITICAL_LIMIT: rd_value[7:0] = crit_limit[0];
         IDX_LOCAL_CRITICAL_LIMIT: rd_value[7:0] = crit_limit[1];
         IDX_REMOTE2_CRITICAL_LIMIT: rd_value[7:0] = crit_limit[2];
         IDX_REMOTE1_LOCAL_HYSTERESIS: rd_value[7:0] = remote1_local_hysteresis;
         IDX_REMOTE2_HYSTERESIS: rd_value[7:0] = remote2_hysteresis;
         IDX_TREE_TEST_ENABLE: rd_value[7:0] = tree_test_enable;
         IDX_REMOTE1_TEMP_OFFSET: rd_value[7:0] = remote1_temp_offset;
         IDX_FAN_CONTROL: rd_value[2:0] = fan_control;
         IDX_IRQ_STATUS: rd_value[IRQ_W-1:0] = irq_status;
         IDX_IRQ_MASK: rd_value[IRQ_W-1:0] = irq_mask;
         IDX_LOOP_STATE: rd_value[8:0] = {pin_sync, overtemp_pin_oe, |crit_hit, crit_hit, fan_active};
         default: mapped = 1'b0;
      endcase
   end

   // ************************************************************
   // apb handshake
   // ************************************************************
   // one wait-free access phase: answer data is latched in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel && !penable && !pready;
         pslverr <= psel && !penable && !mapped;
         prdata <= (psel && !penable && !pwrite) ? rd_value : '0;
      end
   end

   // ************************************************************
   // minimum duty registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         min_duty <= '{default: RST_MIN_DUTY};
      end else if (wr_en && !auto_fan_loop) begin // [R1]
         for (int i = 0; i < NUM_CH; i++) begin
            if (idx == IDX_FAN1_MIN_DUTY + 8'(i)) begin
               min_duty[i] <= pwdata[7:0];
            end
         end
      end
   end

   // ************************************************************
   // lockable threshold registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_start_temp <= '{default: RST_FAN_START_TEMP};
         crit_limit <= '{default: RST_CRITICAL_LIMIT};
      end else if (wr_en && !locked) begin // [R4] [R5]
         for (int i = 0; i < NUM_CH; i++) begin
            if (idx == IDX_REMOTE1_FAN_START_TEMP + 8'(i)) begin
               fan_start_temp[i] <= pwdata[7:0];
            end
            if (idx == IDX_REMOTE1_CRITICAL_LIMIT + 8'(i)) begin
               crit_limit[i] <= pwdata[7:0];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remote1_local_hysteresis <= RST_REMOTE1_LOCAL_HYSTERESIS;
         remote2_hysteresis <= RST_REMOTE2_HYSTERESIS;
         tree_test_enable <= RST_TREE_TEST_ENABLE;
         remote1_temp_offset <= RST_REMOTE1_TEMP_OFFSET;
      end else if (wr_en && !locked) begin // [R5]
         if (idx == IDX_REMOTE1_LOCAL_HYSTERESIS) begin
            remote1_local_hysteresis <= pwdata[7:0];
         end
         if (idx == IDX_REMOTE2_HYSTERESIS) begin
            remote2_hysteresis <= pwdata[7:0];
         end
         if (idx == IDX_TREE_TEST_ENABLE) begin
            // reserved bits are not stored, so they read back as zero
            tree_test_enable <= {7'h00, pwdata[TREE_TEST_BIT]}; // [R13]
         end
         if (idx == IDX_REMOTE1_TEMP_OFFSET) begin
            remote1_temp_offset <= pwdata[7:0];
         end
      end
   end

   // ************************************************************
   // control, interrupt status and mask
   // ************************************************************
   // the lock bit only sets; clearing it needs a reset, so a hung host cannot unlock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_control <= 3'b000;
      end else if (wr_en && idx == IDX_FAN_CONTROL) begin
         fan_control[CTRL_AUTO_FAN_LOOP_BIT] <= pwdata[CTRL_AUTO_FAN_LOOP_BIT];
         fan_control[CTRL_PIN_OUT_BIT] <= pwdata[CTRL_PIN_OUT_BIT];
         fan_control[CTRL_LOCK_BIT] <= locked | pwdata[CTRL_LOCK_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= '0;
      end else if (wr_en && idx == IDX_IRQ_MASK) begin
         irq_mask <= pwdata[IRQ_W-1:0];
      end
   end

   // a new event in the clearing cycle survives the write-one-to-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
      end else if (wr_en && idx == IDX_IRQ_STATUS) begin
         irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_status | irq_event) & irq_mask);
      end
   end

   // ************************************************************
   // readings in quarter-degree code
   // ************************************************************
   always_comb begin
      logic [11:0] sum;
      sum = {2'b00, remote1_temp} + {{3{remote1_temp_offset[7]}}, remote1_temp_offset, 1'b0}; // [R15]
      q_temp[0] = sum[11] ? 10'h000 : (sum[10] ? 10'h3FF : sum[9:0]);
      q_temp[1] = local_temp;
      q_temp[2] = remote2_temp;
      hyst[0] = remote1_local_hysteresis[HYST_HI_MSB -: 4]; // [R10]
      hyst[1] = remote1_local_hysteresis[HYST_LO_MSB -: 4]; // [R10]
      hyst[2] = remote2_hysteresis[HYST_HI_MSB -: 4]; // [R10]
   end

   // ************************************************************
   // fan start and failsafe decisions
   // ************************************************************
   // hysteresis below four degrees is honoured as written; the fan then chatters [R12]
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         next_fan_active[i] = fan_active[i];
         if (q_temp[i] > to_q(fan_start_temp[i])) begin // [R16]
            next_fan_active[i] = 1'b1;
         end else if (q_temp[i] <= minus_hyst(fan_start_temp[i], hyst[i])) begin // [R11]
            next_fan_active[i] = 1'b0;
         end
         next_crit_hit[i] = crit_hit[i];
         if (crit_limit[i] == CRIT_DISABLE_CODE) begin // [R7]
            next_crit_hit[i] = 1'b0;
         end else if (q_temp[i] > to_q(crit_limit[i])) begin // [R6]
            next_crit_hit[i] = 1'b1;
         end else if (q_temp[i] < minus_hyst(crit_limit[i], hyst[i])) begin // [R8]
            next_crit_hit[i] = 1'b0;
         end
         quarter_over[i] = (crit_limit[i] != CRIT_DISABLE_CODE)
            && (q_temp[i] > to_q(crit_limit[i]) + QUARTER_STEP); // [R9]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_active <= '0;
         crit_hit <= '0;
      end else begin
         fan_active <= next_fan_active;
         crit_hit <= next_crit_hit;
      end
   end

   always_comb begin
      irq_event = '0;
      irq_event[IRQ_FAILSAFE_BIT] = |next_crit_hit && !(|crit_hit);
      irq_event[IRQ_OVERTEMP_BIT] = fan_control[CTRL_PIN_OUT_BIT] && |quarter_over && !overtemp_pin_oe;
      irq_event[IRQ_FAN_START_BIT +: NUM_CH] = next_fan_active & ~fan_active;
   end

   // ************************************************************
   // duty computation
   // ************************************************************
   always_comb begin
      logic [7:0] rise;
      logic [15:0] ramp;
      logic [16:0] total;
      rise = 8'h00;
      ramp = '0;
      total = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         rise = (q_temp[i][9:2] > fan_start_temp[i]) ? q_temp[i][9:2] - fan_start_temp[i] : 8'h00;
         ramp = 16'({8'h00, rise} << RAMP_SHIFT);
         total = {9'h000, min_duty[i]} + {1'b0, ramp}; // [R3]
         if (|crit_hit) begin
            next_duty[i] = DUTY_FULL; // [R6] [R8]
         end else if (!fan_active[i]) begin
            next_duty[i] = 8'h00;
         end else if (total > {9'h000, DUTY_FULL}) begin
            next_duty[i] = DUTY_FULL;
         end else begin
            next_duty[i] = total[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty <= '{default: 8'h00};
      end else begin
         duty <= next_duty;
      end
   end

   assign fan1_duty = duty[0];
   assign fan2_duty = duty[1];
   assign fan3_duty = duty[2];

   // ************************************************************
   // pulse-width generation
   // ************************************************************
   // 255-step period: code 0xFF is held high so it reaches full speed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_cnt <= 8'h00;
      end else begin
         pwm_cnt <= (pwm_cnt == 8'hFE) ? 8'h00 : pwm_cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_out <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            pwm_out[i] <= (duty[i] == DUTY_FULL) || (pwm_cnt < duty[i]); // [R2]
         end
      end
   end

   // ************************************************************
   // overtemperature pin and test mode
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= overtemp_pin_i;
         pin_sync <= pin_meta;
      end
   end

   // open drain: the pin is only ever pulled low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overtemp_pin_o <= 1'b0;
         overtemp_pin_oe <= 1'b0;
      end else begin
         overtemp_pin_o <= 1'b0;
         overtemp_pin_oe <= fan_control[CTRL_PIN_OUT_BIT] && |quarter_over; // [R9]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tree_test_mode <= 1'b0;
      end else begin
         tree_test_mode <= tree_test_enable[TREE_TEST_BIT]; // [R13]
      end
   end

endmodule : fclr_regs

// File: fclr_pkg.sv
package fclr_pkg;
   // ************************************************************
   // bus geometry
   // ************************************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = 8;
   // ************************************************************
   // register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [7:0] IDX_FAN1_MIN_DUTY = 8'h64;
   localparam logic [7:0] IDX_FAN2_MIN_DUTY = 8'h65;
   localparam logic [7:0] IDX_FAN3_MIN_DUTY = 8'h66;
   localparam logic [7:0] IDX_REMOTE1_FAN_START_TEMP = 8'h67;
   localparam logic [7:0] IDX_LOCAL_FAN_START_TEMP = 8'h68;
   localparam logic [7:0] IDX_REMOTE2_FAN_START_TEMP = 8'h69;
   localparam logic [7:0] IDX_REMOTE1_CRITICAL_LIMIT = 8'h6A;
   localparam logic [7:0] IDX_LOCAL_CRITICAL_LIMIT = 8'h6B;
   localparam logic [7:0] IDX_REMOTE2_CRITICAL_LIMIT = 8'h6C;
   localparam logic [7:0] IDX_REMOTE1_LOCAL_HYSTERESIS = 8'h6D;
   localparam logic [7:0] IDX_REMOTE2_HYSTERESIS = 8'h6E;
   localparam logic [7:0] IDX_TREE_TEST_ENABLE = 8'h6F;
   localparam logic [7:0] IDX_REMOTE1_TEMP_OFFSET = 8'h70;
   localparam logic [7:0] IDX_FAN_CONTROL = 8'h80;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h81;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h82;
   localparam logic [7:0] IDX_LOOP_STATE = 8'h83;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] RST_MIN_DUTY = 8'h80;
   localparam logic [7:0] RST_FAN_START_TEMP = 8'h9A;
   localparam logic [7:0] RST_CRITICAL_LIMIT = 8'hA4;
   localparam logic [7:0] RST_REMOTE1_LOCAL_HYSTERESIS = 8'h44;
   localparam logic [7:0] RST_REMOTE2_HYSTERESIS = 8'h40;
   localparam logic [7:0] RST_TREE_TEST_ENABLE = 8'h00;
   localparam logic [7:0] RST_REMOTE1_TEMP_OFFSET = 8'h00;
   // ************************************************************
   // field positions and codes
   // ************************************************************
   localparam int CTRL_AUTO_FAN_LOOP_BIT = 0;
   localparam int CTRL_LOCK_BIT = 1;
   localparam int CTRL_PIN_OUT_BIT = 2;
   localparam int IRQ_FAILSAFE_BIT = 0;
   localparam int IRQ_OVERTEMP_BIT = 1;
   localparam int IRQ_FAN_START_BIT = 2;
   localparam int IRQ_W = 5;
   localparam int TREE_TEST_BIT = 0;
   localparam int HYST_LO_MSB = 3;
   localparam int HYST_HI_MSB = 7;
   localparam logic [7:0] CRIT_DISABLE_CODE = 8'h80;
   localparam logic [7:0] DUTY_FULL = 8'hFF;
   localparam logic [9:0] QUARTER_STEP = 10'h001;
   localparam int NUM_CH = 3;
endpackage : fclr_pkg

// File: fclr_monitor.sv
`timescale 1ns/1ps
// ************************************************************
// port checker
// ************************************************************
module fclr_monitor
   import fclr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic overtemp_pin_o,
   input wire logic overtemp_pin_oe,
   input wire logic [7:0] fan1_duty,
   input wire logic [7:0] fan2_duty,
   input wire logic [7:0] fan3_duty,
   input wire logic [2:0] pwm_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [7:0] idx;
   logic bad;
   assign idx = paddr[9:2];
   assign bad = paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0 || idx < 8'h64 || (idx > 8'h70 && idx < 8'h80) || idx > 8'h83;
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_setup_gets_ready: assert property (psel && !penable |=> pready) else $error("no pready after setup");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_idle_rdata_zero: assert property (!pready |-> prdata == '0) else $error("prdata not zero when idle");
   a_unmapped_err: assert property (psel && !penable && bad |=> pslverr && prdata == '0) else $error("bad address");
   a_mapped_no_err: assert property (psel && !penable && !bad |=> !pslverr) else $error("error on mapped address");
   a_full_duty_high: assert property (fan1_duty == 8'hFF |=> pwm_out[0]) else $error("full duty not high");
   a_zero_duty_low: assert property (fan1_duty == 8'h00 |=> !pwm_out[0]) else $error("zero duty not low");
   a_pin_drives_low: assert property (overtemp_pin_o == 1'b0) else $error("pin driven high");
   a_pin_forces_all: assert property (overtemp_pin_oe |=> (fan1_duty & fan2_duty & fan3_duty) == 8'hFF)
      else $error("pin drive without failsafe");
   c_err: cover property (pready && pslverr);
   c_ok: cover property (pready && !pslverr);
   c_pin: cover property (overtemp_pin_oe);
   c_full: cover property (fan2_duty == 8'hFF);
endmodule : fclr_monitor
bind fclr_regs fclr_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .overtemp_pin_o(overtemp_pin_o),
   .overtemp_pin_oe(overtemp_pin_oe), .fan1_duty(fan1_duty), .fan2_duty(fan2_duty), .fan3_duty(fan3_duty),
   .pwm_out(pwm_out));

// File: fclr_fan_model.sv
`timescale 1ns/1ps
// ************************************************************
// fan: counts high cycles over each 255-cycle window
// ************************************************************
module fclr_fan_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pwm,
   output logic [7:0] seen_duty
);
   logic [7:0] win;
   logic [7:0] hi;
   // any aligned window of one full period gives the duty code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win <= 8'h00;
         hi <= 8'h00;
         seen_duty <= 8'h00;
      end else if (win == 8'hFE) begin
         win <= 8'h00;
         hi <= 8'h00;
         seen_duty <= hi + 8'(pwm);
      end else begin
         win <= win + 8'h01;
         hi <= hi + 8'(pwm);
      end
   end
endmodule : fclr_fan_model

// File: fan_control_limit_registers_tb.sv
`timescale 1ns/1ps
module fan_control_limit_registers_tb;
   import fclr_pkg::*;
   localparam int RS = 3;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, pin_oe, pin_o, pin, tmode, irq;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rdat;
   logic [3:0] pstrb;
   logic [9:0] t1, t2, t3;
   logic [7:0] d1, d2, d3, seen;
   logic [2:0] pwm;
   int n_mismatch, n_checks, seed, i, mdl[256], qv[3], qe[3];
   bit act[3], fs[3];
   // open-drain pin with pull-up
   assign pin = pin_oe ? 1'b0 : 1'b1;
   fclr_regs #(.RAMP_SHIFT(RS)) u_fclr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .remote1_temp(t1), .local_temp(t2), .remote2_temp(t3), .overtemp_pin_i(pin),
      .overtemp_pin_o(pin_o), .overtemp_pin_oe(pin_oe), .fan1_duty(d1), .fan2_duty(d2), .fan3_duty(d3),
      .pwm_out(pwm), .tree_test_mode(tmode), .irq(irq));
   fclr_fan_model fan2 (.pclk(pclk), .presetn(presetn), .pwm(pwm[1]), .seen_duty(seen));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // ************************************************************
   // bus and model tasks
   // ************************************************************
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   task chk(input logic [32:0] g, input logic [32:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %0h expected %0h", $time, g, e);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         $display("[ERR] %0t no pready", $time);
         wrap_up();
      end else begin
         rdat = prdata;
         rerr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb
   task wr(input int x, input int d);
      apb(1'b1, {2'b00, 8'(x), 2'b00}, 32'(d));
      if (x >= 8'h64 && x <= 8'h66 && !mdl[8'h80][0]) mdl[x] = d & 255;
      if (x >= 8'h67 && x <= 8'h70 && !mdl[8'h80][1]) mdl[x] = x == 8'h6F ? d & 1 : d & 255;
      if (x == 8'h80) mdl[x] = (d & 7) | (mdl[x] & 2);
      if (x == 8'h82) mdl[x] = d & 31;
   endtask : wr
   task rd(input int x);
      apb(1'b0, {2'b00, 8'(x), 2'b00}, 32'h0);
   endtask : rd
   // software keeps reserved test bits clear and hysteresis at four or more
   task rwr(input int x);
      int v;
      v = $random(seed) & 255;
      if (x == 8'h6F) v &= 1;
      if (x == 8'h6D || x == 8'h6E) v |= 8'h44;
      wr(x, v);
   endtask : rwr
   task chk_all;
      for (int x = 8'h64; x <= 8'h82; x++) begin
         if (x <= 8'h70 || x == 8'h80 || x == 8'h82) begin
            rd(x);
            chk({rerr, rdat}, {1'b0, 32'(mdl[x])});
         end
      end
   endtask : chk_all
   task reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int c = 0; c < 3; c++) begin
         mdl[8'h64 + c] = RST_MIN_DUTY;
         mdl[8'h67 + c] = RST_FAN_START_TEMP;
         mdl[8'h6A + c] = RST_CRITICAL_LIMIT;
         act[c] = 0;
         fs[c] = 0;
      end
      mdl[8'h6D] = RST_REMOTE1_LOCAL_HYSTERESIS;
      mdl[8'h6E] = RST_REMOTE2_HYSTERESIS;
      mdl[8'h6F] = RST_TREE_TEST_ENABLE;
      mdl[8'h70] = RST_REMOTE1_TEMP_OFFSET;
      mdl[8'h80] = 0;
      mdl[8'h82] = 0;
   endtask : reset
   function automatic int duty(input int c);
      int d;
      if (fs[0] || fs[1] || fs[2]) return 255;
      if (!act[c]) return 0;
      d = mdl[8'h64 + c];
      if (qe[c] / 4 > mdl[8'h67 + c]) d += (qe[c] / 4 - mdl[8'h67 + c]) << RS;
      return d > 255 ? 255 : d;
   endfunction : duty
   task tq(input int a, input int b, input int e, input bit pw);
      int s, h, k, q;
      bit oe;
      @(posedge pclk);
      t1 <= 10'(a);
      t2 <= 10'(b);
      t3 <= 10'(e);
      qv = '{a, b, e};
      repeat (4) @(posedge pclk);
      #1;
      oe = 0;
      for (int c = 0; c < 3; c++) begin
         q = qv[c];
         if (c == 0) q += (mdl[8'h70] > 127 ? mdl[8'h70] - 256 : mdl[8'h70]) * 2;
         q = q < 0 ? 0 : (q > 1023 ? 1023 : q);
         s = mdl[8'h67 + c] * 4;
         h = (c == 1 ? mdl[8'h6D] % 16 : mdl[c == 0 ? 8'h6D : 8'h6E] / 16) * 4;
         k = mdl[8'h6A + c] * 4;
         if (q > s) act[c] = 1;
         else if (q <= (s > h ? s - h : 0)) act[c] = 0;
         if (mdl[8'h6A + c] == 128) fs[c] = 0;
         else if (q > k) fs[c] = 1;
         else if (q < k - h) fs[c] = 0;
         if (mdl[8'h80][2] && mdl[8'h6A + c] != 128 && q > k + 1) oe = 1;
         qe[c] = q;
      end
      chk(d1, duty(0));
      chk(d2, duty(1));
      chk(d3, duty(2));
      chk(pin_oe, oe);
      if (pw) begin
         repeat (520) @(posedge pclk);
         #1;
         chk(seen, duty(1));
      end
   endtask : tq
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      int cf[13] = '{8'h40, 8'h40, 8'h40, 8'h78, 8'h78, 8'h78, 8'hA4, 8'h7C, 8'hA4, 8'h44, 8'h40, 0, 0};
      int lq[9] = '{8'h7A*4+3, 8'h77*4, 8'h74*4+1, 8'h74*4, 8'h79*4, 8'h7C*4+1, 8'h7C*4+2, 8'h78*4, 8'h78*4-1};
      logic [11:0] bad[4] = '{12'h1C4, 12'h210, 12'h191, 12'h590};
      seed = 92136;
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hF;
      {t1, t2, t3} = '0;
      n_mismatch = 0;
      n_checks = 0;
      reset();
      chk_all();
      $display("defaults done");
      for (i = 8'h64; i <= 8'h70; i++) rwr(i);
      chk_all();
      for (i = 0; i < 2; i++) begin
         wr(8'h6F, i);
         repeat (2) @(posedge pclk);
         chk(tmode, i[0]);
      end
      for (i = 0; i < 4; i++) begin
         apb(1'b1, bad[i], 32'hFF);
         chk(rerr, 1'b1);
         apb(1'b0, bad[i], 32'h0);
         chk({rerr, rdat}, {1'b1, 32'h0});
      end
      chk_all();
      $display("access done");
      for (i = 0; i < 13; i++) wr(8'h64 + i, cf[i]);
      wr(8'h81, 8'h1F);
      tq(0, 0, 0, 0);
      tq(0, 8'h79*4, 0, 1);
      rd(8'h81);
      chk(rdat, 32'h8);
      chk(irq, 1'b0);
      wr(8'h82, 8'h08);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      wr(8'h81, 8'h08);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      $display("irq done");
      wr(8'h80, 4);
      for (i = 0; i < 9; i++) tq(0, lq[i], 0, i == 6);
      for (i = 0; i < 16; i++) tq(0, 12'h1C0 + ($random(seed) & 63), 0, 0);
      tq(0, 0, 0, 0);
      wr(8'h6B, 8'h80);
      tq(0, 8'h81*4+3, 0, 0);
      wr(8'h70, 8'h04);
      tq(8'h78*4-4, 0, 0, 0);
      wr(8'h70, 8'hFC);
      tq(8'h78*4-4, 0, 0, 0);
      tq(0, 0, 0, 0);
      $display("temperature done");
      wr(8'h80, 1);
      wr(8'h64, 8'h12);
      chk_all();
      wr(8'h80, 2);
      for (i = 8'h67; i <= 8'h70; i++) rwr(i);
      wr(8'h64, 8'h33);
      wr(8'h80, 0);
      chk_all();
      reset();
      chk_all();
      $display("lock and reset done");
      wrap_up();
   end
endmodule : fan_control_limit_registers_tb
